// >>> spi_mode_pkg.sv
// constants, field layouts and carrier types for the spi mode controller
package spi_mode_pkg;

  // register byte addresses on the ahb-lite bus
  localparam logic [7:0] OFF_MODE_CONFIG = 8'h00;
  localparam logic [7:0] OFF_RATE        = 8'h04;
  localparam logic [7:0] OFF_TX_DATA     = 8'h08;
  localparam logic [7:0] OFF_RX_DATA     = 8'h0c;
  localparam logic [7:0] OFF_STATUS      = 8'h10;

  // serial_port_mode_config fields
  localparam int BIT_CONTINUOUS  = 7;
  localparam int BIT_ENABLE      = 6;
  localparam int BIT_OPEN_DRAIN  = 5;
  localparam int BIT_MASTER      = 4;
  localparam int BIT_CPOL        = 3;
  localparam int BIT_CPHA        = 2;
  localparam int BIT_LSB_FIRST   = 1;
  localparam logic [7:0] MODE_CONFIG_RESET = 8'h00;
  localparam logic [1:0] RATE_RESET        = 2'b00;

  // status register fields
  localparam int BIT_ST_BUSY     = 0;
  localparam int BIT_ST_RX_VALID = 1;
  localparam int BIT_ST_TX_FULL  = 2;
  localparam int BIT_ST_TX_EMPTY = 3;
  localparam int POS_ST_COUNT    = 4;

  // transmit fifo shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_CNT_W = 3;

  // serial framing
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
  localparam logic [4:0] HALF_DIV_BASE  = 5'h04;
  localparam logic [7:0] SLAVE_FILL     = 8'hff;

  // idle stall between single-byte master transfers
  localparam int CLK_MHZ      = 200;
  localparam int STALL_NS     = 50;
  localparam int STALL_CYCLES = (STALL_NS * CLK_MHZ + 999) / 1000;
  localparam logic [4:0] STALL_LAST = 5'(STALL_CYCLES - 1);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_XFER,
    ST_STALL
  } xfer_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
  } ahb_aphase_t;

  typedef struct packed {
    logic [7:0]  cfg;
    logic [1:0]  rate;
    ahb_aphase_t ap;
    logic [31:0] rdata;
    xfer_state_t mode;
    logic [4:0]  div_cnt;
    logic [4:0]  edge_cnt;
    logic [4:0]  stall_cnt;
    logic [7:0]  tx_byte;
    logic [7:0]  rx_sh;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        sclk;
    logic        sclk_prev;
    logic        out_bit;
    logic        ss_n;
  } ctrl_state_t;

endpackage : spi_mode_pkg

// >>> tx_fifo.sv
// small synchronous valid/ready fifo holding queued transmit bytes
`timescale 1ns/1ps
module tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int CNT_W = 3
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [CNT_W-1:0] count
);
  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            cnt;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic        push;
  logic        pop;

  assign in_ready  = (q.cnt != CNT_W'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rd_ptr];
  assign count     = q.cnt;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr_ptr] = in_data;
      d.wr_ptr = PTR_W'(q.wr_ptr + 1'b1);
    end
    if (pop) begin
      d.rd_ptr = PTR_W'(q.rd_ptr + 1'b1);
    end
    if (push && !pop) begin
      d.cnt = CNT_W'(q.cnt + 1'b1);
    end else if (pop && !push) begin
      d.cnt = CNT_W'(q.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : tx_fifo

// >>> spi_mode_control.sv
// spi port with mode configuration, ahb-lite registers and framing engine
`timescale 1ns/1ps
module spi_mode_control
  import spi_mode_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        sclk_i,
  output logic             sclk_o,
  output logic             sclk_oe_n,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe_n,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe_n,
  input  wire logic        ss_n_i,
  output logic             ss_n_o,
  output logic             ss_n_oe_n,
  output logic             pullup_en
);

  ctrl_state_t q;
  ctrl_state_t d;

  logic                  fifo_in_valid;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic                  fifo_out_ready;
  logic [FIFO_WIDTH-1:0] fifo_out_data;
  logic [FIFO_CNT_W-1:0] fifo_count;

  logic enabled;
  logic master;
  logic cpha;
  logic lsbf;
  logic odrain;
  logic [4:0] half_last;
  logic dp_tx_write;

  // one bit of a byte in transmit order
  function automatic logic pick_bit(input logic [7:0] b,
                                    input logic [3:0] idx,
                                    input logic       lsb_first);
    logic [2:0] i;
    i = idx[2:0];
    if (lsb_first) begin
      pick_bit = b[i];
    end else begin
      pick_bit = b[3'(3'd7 - i)];
    end
  endfunction : pick_bit

  function automatic logic [7:0] reverse8(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int k = 0; k < 8; k++) begin
      r[k] = b[7 - k];
    end
    reverse8 = r;
  endfunction : reverse8

  assign enabled = q.cfg[BIT_ENABLE];
  assign master  = q.cfg[BIT_MASTER];
  assign cpha    = q.cfg[BIT_CPHA];
  assign lsbf    = q.cfg[BIT_LSB_FIRST];
  assign odrain  = q.cfg[BIT_OPEN_DRAIN];
  // half period of sclk in core cycles: 4, 8, 16 or 32
  assign half_last = 5'((HALF_DIV_BASE << q.rate) - 1'b1);

  // a tx write waits in its data phase while the fifo is full
  assign dp_tx_write   = q.ap.valid & q.ap.write & (q.ap.addr == OFF_TX_DATA);
  assign fifo_in_valid = dp_tx_write;
  assign hreadyout     = ~(dp_tx_write & ~fifo_in_ready);
  assign hresp         = 1'b0;
  assign hrdata        = q.rdata;

  tx_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH),
    .CNT_W (FIFO_CNT_W)
  ) u_tx_fifo (
    .clk       (hclk),
    .rst_n     (hresetn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (hwdata[FIFO_WIDTH-1:0]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .count     (fifo_count)
  );

  always_comb begin
    logic       accept;
    logic       tick;
    logic       sedge;
    logic       in_bit;
    logic       done;
    logic       rx_set;
    logic       rx_clr;
    logic [3:0] oidx;
    logic [31:0] rd;
    accept = 1'b0;
    tick   = 1'b0;
    sedge  = 1'b0;
    in_bit = 1'b0;
    done   = 1'b0;
    rx_set = 1'b0;
    rx_clr = 1'b0;
    oidx   = '0;
    rd     = '0;
    d = q;
    fifo_out_ready = 1'b0;

    // register writes land in the data phase
    if (q.ap.valid && q.ap.write && hreadyout) begin
      case (q.ap.addr)
        OFF_MODE_CONFIG: d.cfg  = hwdata[7:0];
        OFF_RATE:        d.rate = hwdata[1:0];
        default:         d.cfg  = d.cfg;
      endcase
    end

    accept = hsel & htrans[1] & hready;
    if (hready) begin
      d.ap.valid = accept;
      d.ap.write = hwrite;
      d.ap.addr  = haddr[7:0];
    end
    if (accept && !hwrite) begin
      case (haddr[7:0])
        OFF_MODE_CONFIG: rd[7:0] = q.cfg;
        OFF_RATE:        rd[1:0] = q.rate;
        OFF_RX_DATA: begin
          rd[7:0] = q.rx_data;
          rx_clr  = 1'b1;
        end
        OFF_STATUS: begin
          rd[BIT_ST_BUSY]     = (q.mode != ST_IDLE);
          rd[BIT_ST_RX_VALID] = q.rx_valid;
          rd[BIT_ST_TX_FULL]  = ~fifo_in_ready;
          rd[BIT_ST_TX_EMPTY] = ~fifo_out_valid;
          rd[POS_ST_COUNT +: FIFO_CNT_W] = fifo_count;
        end
        default: rd = '0;
      endcase
      d.rdata = rd;
    end

    // edge sources: own divider as master, pin edges as slave
    d.sclk_prev = sclk_i;
    if (master) begin
      in_bit = miso_i;
      tick   = (q.div_cnt == half_last);
      d.div_cnt = tick ? 5'h00 : 5'(q.div_cnt + 1'b1);
      sedge  = (q.mode == ST_XFER) && tick
               && (q.edge_cnt != EDGES_PER_BYTE);
    end else begin
      in_bit = mosi_i;
      sedge  = (q.mode == ST_XFER) && !ss_n_i
               && (sclk_i != q.sclk_prev);
    end

    if (!enabled) begin
      d.mode     = ST_IDLE;
      d.ss_n     = 1'b1;
      d.sclk     = q.cfg[BIT_CPOL];
      d.edge_cnt = '0;
    end else begin
      case (q.mode)
        ST_IDLE: begin
          d.sclk = q.cfg[BIT_CPOL];
          d.edge_cnt = '0;
          d.div_cnt  = '0;
          if (master && fifo_out_valid) begin
            fifo_out_ready = 1'b1;
            d.tx_byte = fifo_out_data;
            d.out_bit = pick_bit(fifo_out_data, 4'h0, lsbf);
            d.ss_n    = 1'b0;
            d.mode    = ST_XFER;
          end else if (!master && !ss_n_i) begin
            fifo_out_ready = fifo_out_valid;
            d.tx_byte = fifo_out_valid ? fifo_out_data : SLAVE_FILL;
            d.out_bit = pick_bit(d.tx_byte, 4'h0, lsbf);
            d.mode    = ST_XFER;
          end
        end
        ST_XFER: begin
          if (sedge) begin
            if (q.edge_cnt[0] == cpha) begin
              d.rx_sh = {q.rx_sh[6:0], in_bit};
            end else begin
              oidx = cpha ? q.edge_cnt[4:1]
                          : 4'((q.edge_cnt + 1'b1) >> 1);
              if (!oidx[3]) begin
                d.out_bit = pick_bit(q.tx_byte, oidx, lsbf);
              end
            end
            d.edge_cnt = 5'(q.edge_cnt + 1'b1);
            if (master) begin
              d.sclk = ~q.sclk;
            end
          end
          done = (q.edge_cnt == EDGES_PER_BYTE) && (!master || tick);
          if (!master && ss_n_i) begin
            d.mode = ST_IDLE;
          end else if (done) begin
            rx_set     = 1'b1;
            d.rx_data  = lsbf ? reverse8(q.rx_sh) : q.rx_sh;
            d.edge_cnt = '0;
            if (master) begin
              if (q.cfg[BIT_CONTINUOUS] && fifo_out_valid) begin
                fifo_out_ready = 1'b1;
                d.tx_byte = fifo_out_data;
                d.out_bit = pick_bit(fifo_out_data, 4'h0, lsbf);
              end else begin
                d.ss_n      = 1'b1;
                d.stall_cnt = '0;
                d.mode      = ST_STALL;
              end
            end else begin
              fifo_out_ready = fifo_out_valid;
              d.tx_byte = fifo_out_valid ? fifo_out_data : SLAVE_FILL;
              d.out_bit = pick_bit(d.tx_byte, 4'h0, lsbf);
            end
          end
        end
        ST_STALL: begin
          d.sclk = q.cfg[BIT_CPOL];
          d.stall_cnt = 5'(q.stall_cnt + 1'b1);
          if (q.stall_cnt == STALL_LAST) begin
            d.mode = ST_IDLE;
          end
        end
        default: d.mode = ST_IDLE;
      endcase
    end

    // a byte landing in the cycle of an rx read keeps its flag
    if (rx_set) begin
      d.rx_valid = 1'b1;
    end else if (rx_clr) begin
      d.rx_valid = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q      <= '0;
      q.cfg  <= MODE_CONFIG_RESET;
      q.rate <= RATE_RESET;
      q.ss_n <= 1'b1;
      q.mode <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // pin drivers: open drain only ever pulls low, oe_n low means driving
  always_comb begin
    logic drv_m;
    logic drv_s;
    drv_m = enabled & master;
    drv_s = enabled & ~master & ~ss_n_i & (q.mode == ST_XFER);
    pullup_en = enabled & ~odrain;
    if (odrain) begin
      sclk_o    = 1'b0;
      mosi_o    = 1'b0;
      miso_o    = 1'b0;
      ss_n_o    = 1'b0;
      sclk_oe_n = ~drv_m | q.sclk;
      mosi_oe_n = ~drv_m | q.out_bit;
      ss_n_oe_n = ~drv_m | q.ss_n;
      miso_oe_n = ~drv_s | q.out_bit;
    end else begin
      sclk_o    = q.sclk;
      mosi_o    = q.out_bit;
      miso_o    = q.out_bit;
      ss_n_o    = q.ss_n;
      sclk_oe_n = ~drv_m;
      mosi_oe_n = ~drv_m;
      ss_n_oe_n = ~drv_m;
      miso_oe_n = ~drv_s;
    end
  end

endmodule : spi_mode_control

// >>> spi_mode_control_sva.sv
// assertions on the pins of the spi mode controller
`timescale 1ns/1ps
module spi_mode_control_chk
  import spi_mode_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        sclk_o,
  input wire logic        sclk_oe_n,
  input wire logic        mosi_oe_n,
  input wire logic        miso_oe_n,
  input wire logic        ss_n_o,
  input wire logic        ss_n_oe_n,
  input wire logic        pullup_en
);
  logic       wc_q, wr_q, sclk_p_q, ss_p_q;
  logic [7:0] cfg_q, ecnt_q;
  logic [1:0] rate_q;
  logic [5:0] gap_q;
  logic       sclk_l, ss_l, mst, acc;
  // open-drain lines float high, so the level is oe_n or value
  assign sclk_l = sclk_oe_n | sclk_o;
  assign ss_l   = ss_n_oe_n | ss_n_o;
  assign mst    = cfg_q[BIT_ENABLE] & cfg_q[BIT_MASTER];
  assign acc    = hsel & htrans[1] & hready & hwrite;
  // mirror of the mode and rate writes, so pins can be tied to them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wc_q <= 1'b0;
      wr_q <= 1'b0;
      cfg_q <= MODE_CONFIG_RESET;
      rate_q <= RATE_RESET;
      sclk_p_q <= 1'b1;
      ss_p_q <= 1'b1;
      gap_q <= 6'h00;
      ecnt_q <= 8'h00;
    end else begin
      if (hready) begin
        wc_q <= acc & (haddr[7:0] == OFF_MODE_CONFIG);
        wr_q <= acc & (haddr[7:0] == OFF_RATE);
      end
      if (hready & wc_q) cfg_q <= hwdata[7:0];
      if (hready & wr_q) rate_q <= hwdata[1:0];
      sclk_p_q <= sclk_l;
      ss_p_q <= ss_l;
      if (sclk_l != sclk_p_q || (!ss_l && ss_p_q)) gap_q <= 6'h00;
      else gap_q <= gap_q + 6'h01;
      if (!ss_l && ss_p_q) ecnt_q <= 8'h00;
      else if (!ss_l && sclk_l != sclk_p_q) ecnt_q <= ecnt_q + 8'h01;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_sel_fall;
    mst && rate_q == 2'b00 && $fell(ss_l);
  endsequence
  sequence s_first_edge;
    ##1 $stable(sclk_l) [*3] ##1 $changed(sclk_l);
  endsequence
  a_disabled_quiet:
    assert property (!cfg_q[BIT_ENABLE] |-> sclk_oe_n && mosi_oe_n
      && miso_oe_n && ss_n_oe_n) else $error("pin driven while off");
  a_pullup_style:
    assert property (pullup_en == (cfg_q[BIT_ENABLE] & ~cfg_q[BIT_OPEN_DRAIN]))
    else $error("pull-up enable wrong");
  a_slave_quiet:
    assert property (cfg_q[BIT_ENABLE] && !cfg_q[BIT_MASTER] |-> sclk_oe_n
      && ss_n_oe_n && mosi_oe_n) else $error("slave drives master pins");
  a_sclk_idle:
    assert property (mst && ss_l && $stable(cfg_q) && cfg_q == $past(cfg_q, 2)
      |-> sclk_l == cfg_q[BIT_CPOL]) else $error("sclk idle level wrong");
  a_first_edge:
    assert property (s_sel_fall |-> s_first_edge)
    else $error("first sclk edge mistimed");
  a_edge_period:
    assert property (mst && !cfg_q[BIT_CONTINUOUS] && !ss_l
      && sclk_l != sclk_p_q |-> gap_q == (6'h04 << rate_q) - 6'h01)
    else $error("sclk half period wrong");
  a_byte_edges:
    assert property (mst && $rose(ss_l) |-> ecnt_q[3:0] == 4'h0
      && ecnt_q != 8'h00) else $error("select released mid byte");
  a_stall_gap:
    assert property (mst && !cfg_q[BIT_CONTINUOUS] && $rose(ss_l)
      |-> ss_l [*8]) else $error("select reasserted without stall");
endmodule : spi_mode_control_chk

bind spi_mode_control spi_mode_control_chk u_chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .sclk_o(sclk_o),
  .sclk_oe_n(sclk_oe_n), .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n),
  .ss_n_o(ss_n_o), .ss_n_oe_n(ss_n_oe_n), .pullup_en(pullup_en));

// >>> spi_dev_model.sv
// behavioural spi peripheral that answers the master port
`timescale 1ns/1ps
module spi_dev_model (
  input  wire logic       clk,
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  input  wire logic       cpha,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic      [7:0] rx,
  output logic      [7:0] n_sel
);
  logic [7:0] sh;
  logic       ph;
  logic       sp;
  logic       cur = 1'b0;
  logic       ssp = 1'b1;
  initial n_sel = 8'h00;
  // deselected it shows the inverse, so a stale bit is never read back
  assign miso = ss_n ? ~cur : cur;
  always @(posedge clk) begin
    sp <= sclk;
    ssp <= ss_n;
    if (ssp && !ss_n) begin
      n_sel <= n_sel + 8'h01;
      ph <= 1'b0;
      sh <= cpha ? tx : {tx[6:0], 1'b0};
      cur <= cpha ? ~cur : tx[7];
    end else if (!ss_n && sclk != sp) begin
      ph <= ~ph;
      if (ph == cpha) rx <= {rx[6:0], mosi};
      else begin
        cur <= sh[7];
        sh <= {sh[6:0], 1'b0};
      end
    end
  end
endmodule : spi_dev_model

// >>> test_spi_mode_control.sv
// self-checking bench for the spi mode controller
`timescale 1ns/1ps
module test_spi_mode_control
  import spi_mode_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic        sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
  logic        ss_n_o, ss_n_oe_n, pullup_en, dev_miso;
  logic        sclk_w, mosi_w, miso_w, ss_w, m_en, m_sclk, m_mosi, m_ss;
  logic [7:0]  cur_cfg, dev_tx, dev_rx, n_sel, n0, cap;
  int          n_mismatch, comparisons, cyc;
  // rows: mode, rate, byte sent, byte the device answers with
  logic [7:0] r_cfg [7] = '{8'h50, 8'h58, 8'h54, 8'h5c, 8'h52, 8'h70, 8'h7e};
  logic [1:0] r_rate [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h1};
  logic [7:0] r_tx [7] = '{8'ha5, 8'h3c, 8'h81, 8'h7e, 8'h12, 8'hc3, 8'h0f};
  logic [7:0] r_dev [7] = '{8'h5a, 8'he1, 8'h42, 8'h99, 8'hf0, 8'h3b, 8'h6d};

  assign hready = hreadyout;
  assign sclk_w = !sclk_oe_n ? sclk_o : (m_en ? m_sclk : 1'b1);
  assign mosi_w = !mosi_oe_n ? mosi_o : (m_en ? m_mosi : 1'b1);
  assign ss_w = !ss_n_oe_n ? ss_n_o : (m_en ? m_ss : 1'b1);
  assign miso_w = !miso_oe_n ? miso_o : dev_miso;

  spi_mode_control u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sclk_i(sclk_w), .sclk_o(sclk_o),
    .sclk_oe_n(sclk_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe_n(mosi_oe_n), .miso_i(miso_w), .miso_o(miso_o),
    .miso_oe_n(miso_oe_n), .ss_n_i(ss_w), .ss_n_o(ss_n_o),
    .ss_n_oe_n(ss_n_oe_n), .pullup_en(pullup_en));
  spi_dev_model u_dev (.clk(hclk), .sclk(sclk_w), .mosi(mosi_w),
    .ss_n(ss_w | m_en), .cpha(cur_cfg[2]), .tx(dev_tx), .miso(dev_miso),
    .rx(dev_rx), .n_sel(n_sel));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    q = hrdata;
  endtask : xfer
  task automatic poll(input logic [31:0] m, v);
    do xfer(1'b0, OFF_STATUS, 32'h0); while ((q & m) !== v);
  endtask : poll
  function automatic logic [7:0] rev(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev[i] = b[7 - i];
  endfunction : rev
  task end_sim;
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    {m_en, m_sclk, m_mosi, m_ss} = 4'h1;
    cur_cfg = 8'h00;
    dev_tx = 8'h00;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 7; i++) begin
      cur_cfg = r_cfg[i];
      dev_tx = r_dev[i];
      xfer(1'b1, OFF_RATE, {30'h0, r_rate[i]});
      xfer(1'b1, OFF_MODE_CONFIG, {24'h00_0000, cur_cfg});
      xfer(1'b1, OFF_TX_DATA, {24'h00_0000, r_tx[i]});
      poll(32'h3, 32'h2);
      xfer(1'b0, OFF_RX_DATA, 32'h0);
      chk("rx", q, cur_cfg[1] ? rev(r_dev[i]) : r_dev[i]);
      chk("dev rx", dev_rx, cur_cfg[1] ? rev(r_tx[i]) : r_tx[i]);
      chk("sclk idle", sclk_w, cur_cfg[3]);
      chk("pullup", pullup_en, !cur_cfg[5]);
      chk("resp", {hresp, hreadyout}, 32'h1);
    end
    // second reset in mid-run
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("pins", {sclk_oe_n, mosi_oe_n, ss_n_oe_n, pullup_en}, 4'he);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, OFF_MODE_CONFIG, 32'h0);
    chk("mode reset", q, 32'h0);
    xfer(1'b0, 8'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    cur_cfg = 8'h10;
    dev_tx = 8'h66;
    xfer(1'b1, OFF_MODE_CONFIG, 32'h10);
    for (int k = 1; k < 5; k++) xfer(1'b1, OFF_TX_DATA, 32'h11 * k);
    n0 = n_sel;
    repeat (40) @(posedge hclk);
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk("held fifo", q, 32'h44);
    chk("sel off", n_sel, n0);
    cur_cfg = 8'hd0;
    xfer(1'b1, OFF_MODE_CONFIG, 32'hd0);
    poll(32'h9, 32'h8);
    chk("sel cont", n_sel, n0 + 8'h01);
    chk("last byte", dev_rx, 8'h44);
    cur_cfg = 8'h50;
    xfer(1'b1, OFF_MODE_CONFIG, 32'h10);
    xfer(1'b1, OFF_TX_DATA, 32'h21);
    xfer(1'b1, OFF_TX_DATA, 32'h22);
    xfer(1'b1, OFF_MODE_CONFIG, 32'h50);
    poll(32'h9, 32'h8);
    chk("sel single", n_sel, n0 + 8'h03);
    xfer(1'b0, OFF_RX_DATA, 32'h0);
    cur_cfg = 8'h40;
    xfer(1'b1, OFF_MODE_CONFIG, 32'h40);
    xfer(1'b1, OFF_TX_DATA, 32'h3c);
    m_en <= 1'b1;
    m_ss <= 1'b0;
    repeat (6) @(posedge hclk);
    for (int i = 7; i >= 0; i--) begin
      m_mosi <= r_tx[0][i];
      repeat (4) @(posedge hclk);
      cap = {cap[6:0], miso_w};
      m_sclk <= 1'b1;
      repeat (4) @(posedge hclk);
      m_sclk <= 1'b0;
    end
    repeat (6) @(posedge hclk);
    m_ss <= 1'b1;
    poll(32'h2, 32'h2);
    m_en <= 1'b0;
    xfer(1'b0, OFF_RX_DATA, 32'h0);
    chk("slave rx", q, 32'ha5);
    chk("slave tx", cap, 8'h3c);
    end_sim();
  end
endmodule : test_spi_mode_control
